// ==== rtl/vser_event_router.sv ====
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Behaviour
// - nine software-selected processor interrupt outputs
// - four software-selected DMA request outputs
// - three irq select registers, one dma select
// - sticky status register polled by software
// - events 0-2 are sensor line-count events
// - event 3 is lens shading interrupt
// - events 4 and 13 are update-allowed events
// - events 5 and 14 fire at last pixel
// - event 9 vsync start, source selectable
// - event 21 encoder vsync rise, 20 display eof
// - event 22 invalid when both formats 2
// - event 23 invalid when both formats 0/1
// - event 24 when both statistics finished
// - event 27 first pixel with defect table enabled
// - event 28 when bank zero becomes empty
// - event 29 when bank one becomes empty
// - interrupt lines 0-8 in selection order
// - system mux on outputs 0, 7, 8
// - dma requests are events 4 to 7
// - sleep controller sync reset clears everything
module vser_event_router
  import vser_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   power_sleep_ctrl_sync_reset,
  input  wire vser_pkg::vser_bus_t    bus,
  output logic [31:0]                 rdata,
  input  wire logic [vser_pkg::N_EVT-1:0] src_event,
  input  wire logic                   vsync_parallel,
  input  wire logic                   vsync_sensor,
  input  wire logic                   first_valid_pixel,
  input  wire logic                   defect_bank0_empty,
  input  wire logic                   defect_bank1_empty,
  input  wire logic                   noise_filter_irq,
  input  wire logic                   coprocessor_irq_1,
  output logic [vser_pkg::N_IRQ-1:0]  video_irq_out,
  output logic [vser_pkg::N_DMA-1:0]  video_dma_req,
  output logic [6:0]                  dma_event_base,
  output vser_pkg::vser_cfg_t         cfg_out
);

  import vser_pkg::*;

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_q1;
  logic rst_q2;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  vser_state_t s;
  vser_state_t next_s;

  logic [N_EVT-1:0] raw;
  logic [N_EVT-1:0] stable;
  logic [N_EVT-1:0] rise;
  logic             fmt_a_hi;
  logic             fmt_b_hi;
  logic             both_two;
  logic             both_low;

  // sources are pins from other clock domains: three stages, agree on 2 and 3
  always_comb begin
    raw            = src_event;
    raw[EV_VSYNC]  = s.cfg.vsync_event_source ? vsync_sensor : vsync_parallel;
    raw[EV_DPC_INI] = first_valid_pixel;
    raw[EV_DPC_RN0] = defect_bank0_empty;
    raw[EV_DPC_RN1] = defect_bank1_empty;
    raw            = raw & ~RSV_MASK;
  end

  assign stable   = s.sync2 & s.sync3;
  assign fmt_a_hi = s.cfg.resizer_a_chroma_format == 2'd2;
  assign fmt_b_hi = s.cfg.resizer_b_chroma_format == 2'd2;
  assign both_two = fmt_a_hi && fmt_b_hi;
  assign both_low = (s.cfg.resizer_a_chroma_format < 2'd2)
                 && (s.cfg.resizer_b_chroma_format < 2'd2);

  // plain source events become one-cycle pulses on their rising edge
  assign rise = stable & ~s.evt;

  always_comb begin
    next_s       = s;
    next_s.sync1 = raw;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    next_s.evt   = stable;

    next_s.af_done  = s.af_done  | rise[EV_AF];
    next_s.aew_done = s.aew_done | rise[EV_AEW];

    next_s.first_pix   = stable[EV_DPC_INI];
    next_s.bank0_empty = stable[EV_DPC_RN0];
    next_s.bank1_empty = stable[EV_DPC_RN1];

    // ************************************************************
    // derived events
    // ************************************************************
    begin : derive
      logic [N_EVT-1:0] ev;
      logic [N_EVT-1:0] gate;
      ev   = rise;
      gate = '0;
      if (both_two) begin
        ev[EV_EOF0] = 1'b0;
      end
      if (both_low) begin
        ev[EV_EOF1] = 1'b0;
      end
      // later of the two statistics completions
      ev[EV_H3A] = (s.af_done | rise[EV_AF]) && (s.aew_done | rise[EV_AEW]);
      if (ev[EV_H3A]) begin
        next_s.af_done  = 1'b0;
        next_s.aew_done = 1'b0;
      end
      ev[EV_DPC_INI] = stable[EV_DPC_INI] && !s.first_pix
                    && s.cfg.defect_table_enable;
      ev[EV_DPC_RN0] = stable[EV_DPC_RN0] && !s.bank0_empty;
      ev[EV_DPC_RN1] = stable[EV_DPC_RN1] && !s.bank1_empty;
      gate = ev & ~RSV_MASK;

      // ************************************************************
      // routing
      // ************************************************************
      for (int i = 0; i < N_IRQ; i++) begin
        // select codes 30 and 31 name no event and route a quiet zero
        next_s.irq[i] = (s.irq_route_select[i] < N_EVT)
                     && gate[s.irq_route_select[i]];
      end
      // system mux: zero selects the video event
      if (s.system_interrupt_mux_select[MUX_OUT0]) begin
        next_s.irq[0] = 1'b0;
      end
      if (s.system_interrupt_mux_select[MUX_OUT7]) begin
        next_s.irq[7] = noise_filter_irq;
      end
      if (s.system_interrupt_mux_select[MUX_OUT8]) begin
        next_s.irq[8] = coprocessor_irq_1;
      end
      for (int j = 0; j < N_DMA; j++) begin
        next_s.dma[j] = (s.dma_route_select[j] < N_EVT)
                     && gate[s.dma_route_select[j]];
      end

      // ************************************************************
      // register port
      // ************************************************************
      next_s.rdata = 32'h0000_0000;
      if (bus.rd) begin
        case (bus.addr)
          OFF_IRQ_SEL1: begin
            for (int k = 0; k < 4; k++) begin
              next_s.rdata[k*SEL_STRIDE +: SEL_W] = s.irq_route_select[k];
            end
          end
          OFF_IRQ_SEL2: begin
            for (int k = 0; k < 4; k++) begin
              next_s.rdata[k*SEL_STRIDE +: SEL_W] = s.irq_route_select[k+4];
            end
          end
          OFF_IRQ_SEL3: begin
            next_s.rdata[SEL_W-1:0] = s.irq_route_select[8];
          end
          OFF_DMA_SEL: begin
            for (int k = 0; k < N_DMA; k++) begin
              next_s.rdata[k*SEL_STRIDE +: SEL_W] = s.dma_route_select[k];
            end
          end
          OFF_STATUS: begin
            next_s.rdata[N_EVT-1:0] = s.event_poll_status;
          end
          OFF_SYS_MUX: begin
            next_s.rdata = s.system_interrupt_mux_select;
          end
          OFF_CFG: begin
            next_s.rdata[5:0] = s.cfg;
          end
          default: begin
            next_s.rdata = 32'h0000_0000;
          end
        endcase
      end

      // status: write one to clear, a new event wins over the clear
      next_s.event_poll_status = s.event_poll_status;
      if (bus.wr) begin
        case (bus.addr)
          OFF_IRQ_SEL1: begin
            for (int k = 0; k < 4; k++) begin
              next_s.irq_route_select[k] = bus.wdata[k*SEL_STRIDE +: SEL_W];
            end
          end
          OFF_IRQ_SEL2: begin
            for (int k = 0; k < 4; k++) begin
              next_s.irq_route_select[k+4] = bus.wdata[k*SEL_STRIDE +: SEL_W];
            end
          end
          OFF_IRQ_SEL3: begin
            next_s.irq_route_select[8] = bus.wdata[SEL_W-1:0];
          end
          OFF_DMA_SEL: begin
            for (int k = 0; k < N_DMA; k++) begin
              next_s.dma_route_select[k] = bus.wdata[k*SEL_STRIDE +: SEL_W];
            end
          end
          OFF_STATUS: begin
            next_s.event_poll_status = s.event_poll_status & ~bus.wdata[N_EVT-1:0];
          end
          OFF_SYS_MUX: begin
            next_s.system_interrupt_mux_select = bus.wdata & MUX_WMASK;
          end
          OFF_CFG: begin
            next_s.cfg = bus.wdata[5:0];
          end
          default: begin
          end
        endcase
      end
      next_s.event_poll_status = next_s.event_poll_status | gate;
    end

    if (power_sleep_ctrl_sync_reset) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_q2) begin
    if (!rst_q2) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata          = s.rdata;
  assign video_irq_out  = s.irq;
  assign video_dma_req  = s.dma;
  assign dma_event_base = DMA_EVT_BASE;
  assign cfg_out        = s.cfg;

endmodule

// ==== rtl/vser_pkg.sv ====
package vser_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned N_EVT  = 30;
  localparam int unsigned N_IRQ  = 9;
  localparam int unsigned N_DMA  = 4;
  localparam int unsigned SEL_W  = 5;
  localparam int unsigned ADDR_W = 8;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_IRQ_SEL1 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_SEL2 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_SEL3 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DMA_SEL  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SYS_MUX  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CFG      = 8'h18;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int unsigned SEL_STRIDE = 8;
  localparam int unsigned MUX_OUT0   = 31;
  localparam int unsigned MUX_OUT7   = 25;
  localparam int unsigned MUX_OUT8   = 24;
  localparam logic [31:0] MUX_WMASK  = 32'h8300_0000;
  localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
  localparam logic [N_EVT-1:0] RSV_MASK = 30'h000c_9040;
  localparam logic [6:0] DMA_EVT_BASE = 7'h04;

  // event numbers
  localparam int unsigned EV_LSC     = 3;
  localparam int unsigned EV_PIPE_LP = 5;
  localparam int unsigned EV_VSYNC   = 9;
  localparam int unsigned EV_AEW     = 10;
  localparam int unsigned EV_AF      = 11;
  localparam int unsigned EV_RSZ_LP  = 14;
  localparam int unsigned EV_EOF0    = 22;
  localparam int unsigned EV_EOF1    = 23;
  localparam int unsigned EV_H3A     = 24;
  localparam int unsigned EV_DPC_INI = 27;
  localparam int unsigned EV_DPC_RN0 = 28;
  localparam int unsigned EV_DPC_RN1 = 29;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } vser_bus_t;

  typedef struct packed {
    logic [1:0] resizer_a_chroma_format;
    logic [1:0] resizer_b_chroma_format;
    logic       vsync_event_source;
    logic       defect_table_enable;
  } vser_cfg_t;

  typedef struct packed {
    logic [N_EVT-1:0] sync1;
    logic [N_EVT-1:0] sync2;
    logic [N_EVT-1:0] sync3;
    logic [N_EVT-1:0] evt;
    logic             af_done;
    logic             aew_done;
    logic             first_pix;
    logic             bank0_empty;
    logic             bank1_empty;
    logic [N_IRQ-1:0][SEL_W-1:0] irq_route_select;
    logic [N_DMA-1:0][SEL_W-1:0] dma_route_select;
    logic [N_EVT-1:0] event_poll_status;
    logic [31:0]      system_interrupt_mux_select;
    vser_cfg_t        cfg;
    logic [N_IRQ-1:0] irq;
    logic [N_DMA-1:0] dma;
    logic [31:0]      rdata;
  } vser_state_t;

endpackage

// ==== tb/vser_event_router_chk.sv ====
`timescale 1ns/1ps
module vser_router_chk
  import vser_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic                        power_sleep_ctrl_sync_reset,
  input wire vser_pkg::vser_bus_t         bus,
  input wire logic [31:0]                 rdata,
  input wire logic [vser_pkg::N_IRQ-1:0]  video_irq_out,
  input wire logic [vser_pkg::N_DMA-1:0]  video_dma_req,
  input wire logic [6:0]                  dma_event_base,
  input wire vser_pkg::vser_cfg_t         cfg_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic srst;
  assign srst = power_sleep_ctrl_sync_reset;
  AST_DMA_BASE: assert property (dma_event_base == 7'h04)
    else $error("dma event base wrong");
  AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
  AST_RD_UNMAPPED: assert property (bus.rd && bus.addr > 8'h18 && !srst |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_IRQ_PULSE: assert property ((video_irq_out[6:1] & $past(video_irq_out[6:1])) == 6'h0)
    else $error("irq pulse longer than one cycle");
  AST_DMA_PULSE: assert property ((video_dma_req & $past(video_dma_req)) == 4'h0)
    else $error("dma pulse longer than one cycle");
  AST_SYNC_RST: assert property (srst |=> video_irq_out == 9'h0 && video_dma_req == 4'h0
    && cfg_out == 6'h0 && rdata == 32'h0)
    else $error("sync reset left state");
  AST_CFG_WRITE: assert property (bus.wr && bus.addr == OFF_CFG && !srst
    |=> cfg_out == $past(bus.wdata[5:0]))
    else $error("config copy wrong");
  AST_CFG_HOLD: assert property (!bus.wr && !$past(bus.wr) && !srst |=> $stable(cfg_out))
    else $error("config changed without write");
  AST_QUIET_RELEASE: assert property ($rose(rst_b) |-> (video_irq_out == 9'h0
    && video_dma_req == 4'h0) [*2])
    else $error("output active after reset release");
endmodule
bind vser_event_router vser_router_chk u_chk (.clk(clk), .rst_b(rst_b),
  .power_sleep_ctrl_sync_reset(power_sleep_ctrl_sync_reset), .bus(bus), .rdata(rdata),
  .video_irq_out(video_irq_out), .video_dma_req(video_dma_req),
  .dma_event_base(dma_event_base), .cfg_out(cfg_out));

// ==== tb/vser_irq_sink.sv ====
`timescale 1ns/1ps
module vser_irq_sink
  import vser_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic                        clr,
  input wire logic [vser_pkg::N_IRQ-1:0]  irq,
  input wire logic [vser_pkg::N_DMA-1:0]  dma,
  output logic [12:0]                     seen,
  output int                              hits
);
  // slots 0-8 are interrupt lines, slots 9-12 dma events 4-7
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b || clr) begin
      seen <= '0;
      hits <= 0;
    end else begin
      seen <= seen | {dma, irq};
      hits <= hits + $countones({dma, irq});
    end
  end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import vser_pkg::*;
  logic clk = 0, rst_b = 0, srst = 0, nf = 0, cp = 0, clr = 0;
  logic vs_p = 0, vs_s = 0, fvp = 0, b0 = 0, b1 = 0;
  vser_bus_t bus = '0;
  logic [N_EVT-1:0] src = '0;
  logic [31:0] rdata;
  logic [N_IRQ-1:0] irq;
  logic [N_DMA-1:0] dma;
  logic [6:0] base;
  vser_cfg_t cfg;
  logic [12:0] seen;
  int hits, num_errors = 0, cmp_count = 0;
  int ev[18] = '{0, 1, 2, 3, 4, 5, 13, 14, 21, 9, 20, 22, 27, 28, 29, 24, 23, 6};
  int sl[18] = '{1, 2, 3, 4, 5, 6, 7, 8, 0, 9, 10, 11, 12, 1, 2, 3, 4, 5};
  vser_event_router u_dut (.clk(clk), .rst_b(rst_b), .power_sleep_ctrl_sync_reset(srst),
    .bus(bus), .rdata(rdata), .src_event(src), .vsync_parallel(vs_p), .vsync_sensor(vs_s),
    .first_valid_pixel(fvp), .defect_bank0_empty(b0), .defect_bank1_empty(b1),
    .noise_filter_irq(nf), .coprocessor_irq_1(cp), .video_irq_out(irq),
    .video_dma_req(dma), .dma_event_base(base), .cfg_out(cfg));
  vser_irq_sink u_sink (.clk(clk), .rst_b(rst_b), .clr(clr), .irq(irq), .dma(dma),
    .seen(seen), .hits(hits));
  always #5 clk = ~clk;
  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) bus <= {a, d, 2'b10};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk) bus <= {a, 32'h0000_0000, 2'b01};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // drives the source that raises event e
  task automatic fire(input int e, input logic lvl);
    case (e)
      9: vs_p <= lvl;
      24: begin src[10] <= lvl; src[11] <= lvl; end
      27: fvp <= lvl;
      28: b0 <= lvl;
      29: b1 <= lvl;
      default: src[e] <= lvl;
    endcase
  endtask
  initial begin
    #500us;
    num_errors++;
    conclude();
  end
  initial begin
    logic [31:0] sel [4];
    int s, r, f, h;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(base), 32'h0000_0004);
    for (int a = 0; a < 8; a++) rd(8'(a * 4), 32'h0000_0000);
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h0000_0000);
    wr(OFF_SYS_MUX, 32'hffff_ffff);
    rd(OFF_SYS_MUX, 32'h8300_0000);
    @(posedge clk) {nf, cp} <= 2'b11;
    repeat (3) @(posedge clk);
    #1 chk(32'(irq), 32'h0000_0180);
    wr(OFF_SYS_MUX, 32'h0000_0000);
    @(posedge clk) {nf, cp} <= 2'b00;
    wr(OFF_CFG, 32'h0000_0001);
    rd(OFF_CFG, 32'h0000_0001);
    chk(32'(cfg), 32'h0000_0001);
    for (int i = 0; i < 18; i++) begin
      s = sl[i];
      h = (ev[i] != 23 && ev[i] != 6);
      sel = '{4{32'h0606_0606}};
      r = (s < 9) ? s / 4 : 3;
      f = (s < 9) ? s % 4 : s - 9;
      sel[r][f * 8 +: 5] = 5'(ev[i]);
      for (int k = 0; k < 4; k++) wr(8'(k * 4), sel[k]);
      @(posedge clk) clr <= 1'b1;
      fire(ev[i], 1'b1);
      @(posedge clk) clr <= 1'b0;
      repeat (3) @(posedge clk);
      fire(ev[i], 1'b0);
      repeat (8) @(posedge clk);
      #1 chk(32'(hits), 32'(h));
      chk(32'(seen), h ? (32'h1 << s) : 32'h0);
      rd(OFF_STATUS, !h ? 32'h0 : ev[i] == 24 ? 32'h0100_0c00 : 32'h1 << ev[i]);
      wr(OFF_STATUS, 32'h3fff_ffff);
    end
    rd(OFF_DMA_SEL, sel[3]);
    wr(OFF_CFG, 32'h0000_0003);
    wr(OFF_IRQ_SEL1, 32'h0606_0906);
    @(posedge clk) clr <= 1'b1;
    vs_p <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk(32'(hits), 32'h0000_0000);
    @(posedge clk) vs_s <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk(32'(seen), 32'h0000_0002);
    wr(OFF_SYS_MUX, 32'h8000_0000);
    wr(OFF_IRQ_SEL1, 32'h0606_0909);
    @(posedge clk) vs_s <= 1'b0;
    repeat (6) @(posedge clk);
    clr <= 1'b1;
    vs_s <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk(32'(seen), 32'h0000_0002);
    wr(OFF_CFG, 32'h0000_003f);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    rd(OFF_CFG, 32'h0000_0000);
    rd(OFF_IRQ_SEL1, 32'h0000_0000);
    chk(32'(cfg), 32'h0000_0000);
    conclude();
  end
endmodule
